// ==== core/rlm_line_mode.sv ====
// Line-mode logic of one UART channel: half-duplex driver enable,
// receiver gating, transmit interrupt gating and infrared coding.
// Assumes the UART core, on clk, supplies the 16x baud tick, the transmit
// stream, FIFO and shift-register status, and takes the receive stream.
//
// Notes on behaviour
// - Three-bit field sets enable hold in bit times
// - Hold starts when both empty; write cancels
// - Listen on, no echo: store, all interrupts
// - Listen off plain mode: no timeout interrupt
// - Listen off half-duplex/infrared: discard everything
// - Echo: always store; no timeout unless listen
// - Enable rises one bit before first stop
// - Enable stays high while data pending
// - Large-block: transmit interrupt as normal mode
// - Otherwise half-duplex transmit interrupt waits shift-register empty
// - Infrared single bits, up to 115.2 kbps
// - Coding clock sixteen ticks per bit
// - Infrared pulse three ticks, at least 1.6 us
// - Stream high: infrared output low, counter cleared
// - Stream low: pulse ticks seven to nine
// - Reset: decoded line high, counter cleared
// - Falling edge: decoded low sixteen ticks
// - Receiver samples mid-bit, eighth tick then sixteen
// - Decoder accepts negative and positive pulses
// - Half-duplex without large-block holds transmit interrupts until shift empty
// - Bit one enables infrared path
// - Half-duplex without listen: receiver off transmitting
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module rlm_line_mode (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic baud16_tick,
  input wire logic int_tx,
  input wire logic tsr_empty,
  input wire logic thr_empty,
  input wire logic thr_write,
  input wire logic tx_stop_next,
  input wire logic tx_int_raw,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic driver_enable_out,
  output logic rx_line,
  output logic rx_sample_strobe,
  output logic rx_store_en,
  output logic rx_int_en,
  output logic rx_timeout_en,
  output logic tx_int_req
);

  typedef struct packed {
    logic [7:0] afc;
    logic echo;
    logic ack;
    logic [31:0] rdat;
    logic rs1;
    logic rs2;
    logic de;
    logic hold;
    logic [2:0] hold_bits;
    logic [3:0] hold_tick;
    logic tx;
    logic rxl;
    logic sprev;
    logic sact;
    logic [3:0] scnt;
    logic [3:0] sbits;
    logic strobe;
    logic store;
    logic inten;
    logic tmo;
    logic txint;
  } rlm_core_st_t;

  localparam rlm_core_st_t ST_RESET = '{
    afc: rlm_pkg::AFC_RESET,
    echo: rlm_pkg::ECHO_RESET,
    ack: 1'h0,
    rdat: 32'h0000_0000,
    rs1: 1'h1,
    rs2: 1'h1,
    de: 1'h0,
    hold: 1'h0,
    hold_bits: 3'h0,
    hold_tick: 4'h0,
    tx: 1'h1,
    rxl: 1'h1,
    sprev: 1'h1,
    sact: 1'h0,
    scnt: 4'h0,
    sbits: 4'h0,
    strobe: 1'h0,
    store: 1'h1,
    inten: 1'h1,
    tmo: 1'h0,
    txint: 1'h0
  };

  rlm_core_st_t st_reg;
  rlm_core_st_t st_next;

  rlm_sir_if sir ();

  rlm_sir_codec u_codec (
    .clk(clk),
    .arst_n(arst_n),
    .sir(sir)
  );

  // Register decode shared by the read and the write paths
  function automatic rlm_pkg::rlm_reg_t reg_sel(input logic [7:0] adr);
    unique case (adr)
      rlm_pkg::AFC_OFS: reg_sel = rlm_pkg::REG_AFC;
      rlm_pkg::CTL_OFS: reg_sel = rlm_pkg::REG_CTL;
      rlm_pkg::STS_OFS: reg_sel = rlm_pkg::REG_STS;
      default: reg_sel = rlm_pkg::REG_NONE;
    endcase
  endfunction

  logic ir_mode;
  logic hd_mode;
  logic lg_opt;
  logic listen;
  logic [2:0] dly;
  logic pending;
  logic rx_open;
  logic bus_req;

  assign ir_mode = st_reg.afc[rlm_pkg::IR_BIT];
  assign hd_mode = st_reg.afc[rlm_pkg::HD_BIT];
  assign lg_opt = st_reg.afc[rlm_pkg::LG_BIT];
  assign listen = st_reg.afc[rlm_pkg::LISTEN_BIT];
  assign dly = st_reg.afc[rlm_pkg::DLY_MSB:rlm_pkg::DLY_LSB];
  assign pending = !tsr_empty || !thr_empty;
  assign bus_req = wb_cyc_i && wb_stb_i;
  // Half-duplex or infrared without listen shuts the receiver, so it never
  // hears its own transmission; echo always keeps it open
  assign rx_open = st_reg.echo || listen || !(hd_mode || ir_mode);

  // Coding clock is the baud generator tick itself
  assign sir.tick = baud16_tick;
  assign sir.int_tx = int_tx;
  assign sir.rx_sync = st_reg.rs2;

  always_comb begin
    st_next = st_reg;
    st_next.strobe = 1'h0;

    // Wishbone slave: read data loads with the request, ack one cycle later
    st_next.ack = bus_req && !st_reg.ack;
    if (bus_req && !st_reg.ack) begin
      unique case (reg_sel(wb_adr_i))
        rlm_pkg::REG_AFC: st_next.rdat = {24'h00_0000, st_reg.afc};
        rlm_pkg::REG_CTL: st_next.rdat = {31'h0000_0000, st_reg.echo};
        rlm_pkg::REG_STS: begin
          st_next.rdat = 32'h0000_0000;
          st_next.rdat[rlm_pkg::STS_DE_BIT] = st_reg.de;
          st_next.rdat[rlm_pkg::STS_HOLD_BIT] = st_reg.hold;
          st_next.rdat[rlm_pkg::STS_RXL_BIT] = st_reg.rxl;
          st_next.rdat[rlm_pkg::STS_STORE_BIT] = st_reg.store;
        end
        rlm_pkg::REG_NONE: st_next.rdat = 32'h0000_0000;
      endcase
    end
    // Writes take effect on the edge where the master sees ack
    if (bus_req && st_reg.ack && wb_we_i && wb_sel_i[0]) begin
      unique case (reg_sel(wb_adr_i))
        rlm_pkg::REG_AFC: st_next.afc = wb_dat_i[7:0];
        rlm_pkg::REG_CTL: st_next.echo = wb_dat_i[rlm_pkg::ECHO_BIT];
        rlm_pkg::REG_STS: st_next.echo = st_reg.echo;
        rlm_pkg::REG_NONE: st_next.echo = st_reg.echo;
      endcase
    end

    // Receive pin synchroniser
    st_next.rs1 = rx_pin;
    st_next.rs2 = st_reg.rs1;

    // Driver enable and its hold delay
    if (!hd_mode || st_reg.echo) begin
      st_next.de = 1'h0;
      st_next.hold = 1'h0;
    end else begin
      if (tx_stop_next) begin
        st_next.de = 1'h1;
      end
      if (thr_write) begin
        st_next.hold = 1'h0;
      end else if (st_reg.hold) begin
        if (baud16_tick) begin
          st_next.hold_tick = st_reg.hold_tick + 4'h1;
          if (st_reg.hold_tick == rlm_pkg::BIT_LAST) begin
            if (st_reg.hold_bits == 3'h1) begin
              st_next.hold = 1'h0;
              st_next.de = 1'h0;
            end else begin
              st_next.hold_bits = st_reg.hold_bits - 3'h1;
            end
          end
        end
      end else if (st_reg.de && !pending && !tx_stop_next) begin
        // Only an idle transmitter starts the hold; pending data keeps enable up
        if (dly == 3'h0) begin
          st_next.de = 1'h0;
        end else begin
          st_next.hold = 1'h1;
          st_next.hold_bits = dly;
          st_next.hold_tick = 4'h0;
        end
      end
    end

    // Transmit pin: idle level while echo keeps the pins inactive
    if (st_reg.echo) begin
      st_next.tx = !ir_mode;
    end else if (ir_mode) begin
      st_next.tx = sir.ir_tx;
    end else begin
      st_next.tx = int_tx;
    end

    // Receive stream to the UART receiver
    if (st_reg.echo) begin
      st_next.rxl = int_tx;
    end else if (ir_mode) begin
      st_next.rxl = sir.int_rx;
    end else begin
      st_next.rxl = st_reg.rs2;
    end

    // Receiver and interrupt gating
    st_next.store = rx_open;
    st_next.inten = rx_open;
    st_next.tmo = rx_open && listen;

    // Transmit interrupt: in half-duplex without large block, wait for
    // the shift register, so software is not woken mid-packet
    if (hd_mode && !lg_opt) begin
      st_next.txint = tx_int_raw && tsr_empty;
    end else begin
      st_next.txint = tx_int_raw;
    end

    // Mid-bit sample strobe, resynchronised on each start bit
    if (baud16_tick) begin
      st_next.sprev = st_reg.rxl;
      if (!st_reg.sact) begin
        if (st_reg.sprev && !st_reg.rxl) begin
          st_next.sact = 1'h1;
          st_next.scnt = 4'h0;
          st_next.sbits = 4'h0;
        end
      end else begin
        st_next.scnt = st_reg.scnt + 4'h1;
        if (st_next.scnt == rlm_pkg::SMP_MID) begin
          st_next.strobe = st_reg.store;
          st_next.sbits = st_reg.sbits + 4'h1;
          if (st_next.sbits == rlm_pkg::FRAME_BITS) begin
            st_next.sact = 1'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign tx_pin = st_reg.tx;
  assign driver_enable_out = st_reg.de;
  assign rx_line = st_reg.rxl;
  assign rx_sample_strobe = st_reg.strobe;
  assign rx_store_en = st_reg.store;
  assign rx_int_en = st_reg.inten;
  assign rx_timeout_en = st_reg.tmo;
  assign tx_int_req = st_reg.txint;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic hd_live;
  assign hd_live = hd_mode && !st_reg.echo;

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_idle_start;
    hd_live && st_reg.de && !pending && !st_reg.hold && !thr_write && !tx_stop_next;
  endsequence

  a_bus_answer: assert property (s_bus_req |=> s_bus_answer)
    else $error("bus answer not one cycle");
  a_de_stop_rise: assert property (hd_live && tx_stop_next ##1 hd_live
      |-> driver_enable_out)
    else $error("enable did not rise before stop bit");
  a_de_pending: assert property (hd_live && st_reg.de && pending ##1 hd_live
      |-> driver_enable_out)
    else $error("enable dropped with data pending");
  a_hold_start: assert property ((s_idle_start and (dly != 3'h0)) ##1 hd_live
      |-> st_reg.hold && st_reg.hold_bits == $past(dly))
    else $error("hold delay not loaded");
  a_hold_zero: assert property ((s_idle_start and (dly == 3'h0)) |=> !driver_enable_out)
    else $error("zero delay kept enable high");
  a_hold_cancel: assert property (st_reg.hold && thr_write |=> !st_reg.hold)
    else $error("write did not cancel hold");
  a_hold_expiry: assert property ($fell(st_reg.hold) && !$past(thr_write)
      |-> !driver_enable_out)
    else $error("enable high after hold expired");
  a_rx_discard: assert property (!st_reg.echo && !listen && (hd_mode || ir_mode)
      |=> !rx_store_en && !rx_int_en)
    else $error("receiver open while gated");
  a_timeout_off: assert property (!listen |=> !rx_timeout_en)
    else $error("timeout interrupt offered without listen");
  a_txint_hold: assert property (hd_mode && !lg_opt && !tsr_empty |=> !tx_int_req)
    else $error("transmit interrupt before shift empty");
  a_strobe_mid: assert property (rx_sample_strobe |-> st_reg.scnt == rlm_pkg::SMP_MID)
    else $error("sample strobe off mid-bit");

endmodule // rlm_line_mode

// ==== core/rlm_pkg.sv ====
// Shared constants and types for the RS-485 / infrared line-mode block.
// Assumes a 10 MHz system clock and a 16x baud tick from the UART core.
package rlm_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] AFC_OFS = 8'h00;
  localparam logic [7:0] CTL_OFS = 8'h04;
  localparam logic [7:0] STS_OFS = 8'h08;

  // Values after reset
  localparam logic [7:0] AFC_RESET = 8'h00;
  localparam logic ECHO_RESET = 1'h0;

  // alternate_function_control field positions
  localparam int IR_BIT = 1;
  localparam int HD_BIT = 2;
  localparam int LG_BIT = 3;
  localparam int LISTEN_BIT = 4;
  localparam int DLY_LSB = 5;
  localparam int DLY_MSB = 7;

  // Control register: internal_echo_select
  localparam int ECHO_BIT = 0;

  // Status register field positions
  localparam int STS_DE_BIT = 0;
  localparam int STS_HOLD_BIT = 1;
  localparam int STS_RXL_BIT = 2;
  localparam int STS_STORE_BIT = 3;

  // Coding-clock counts within one sixteen-tick bit, and bits sampled per frame
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] ENC_RISE = 4'h7;
  localparam logic [3:0] ENC_FALL = 4'hA;
  localparam logic [3:0] DEC_LAST = 4'hF;
  localparam logic [3:0] SMP_MID = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'hA;

  // Least infrared pulse width, rounded up to whole clocks
  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_MIN_NS = 1600;
  localparam int PULSE_MIN_CYC_I = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] PULSE_MIN_CYC = 5'(PULSE_MIN_CYC_I);

  typedef enum logic [1:0] {REG_AFC, REG_CTL, REG_STS, REG_NONE} rlm_reg_t;

endpackage

// ==== core/rlm_sir_codec.sv ====
// Serial infrared pulse encoder and decoder, one bit at a time.
// Assumes rx_sync is already synchronised and tick is a one-cycle 16x pulse.
`timescale 1ns/1ns
module rlm_sir_codec (
  input wire logic clk,
  input wire logic arst_n,
  rlm_sir_if.codec sir
);

  typedef struct packed {
    logic [3:0] enc_cnt;
    logic [4:0] wid;
    logic ir_tx;
    logic rx_prev;
    logic pend;
    logic [3:0] dec_cnt;
    logic int_rx;
  } rlm_codec_st_t;

  localparam rlm_codec_st_t ST_RESET = '{enc_cnt: 4'h0, wid: 5'h00, ir_tx: 1'h0,
    rx_prev: 1'h1, pend: 1'h0, dec_cnt: 4'h0, int_rx: 1'h1};

  rlm_codec_st_t st_reg;
  rlm_codec_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (sir.int_tx) begin
      st_next.enc_cnt = 4'h0;
      st_next.ir_tx = 1'h0;
    end else begin
      if (sir.tick) begin
        st_next.enc_cnt = st_reg.enc_cnt + 4'h1;
      end
      // Pulse spans ticks 7..9; stretched if ticks run faster than allowed
      st_next.ir_tx = (st_next.enc_cnt >= rlm_pkg::ENC_RISE &&
                       st_next.enc_cnt < rlm_pkg::ENC_FALL) ||
                      (st_reg.ir_tx && st_reg.wid < rlm_pkg::PULSE_MIN_CYC);
    end
    if (!st_next.ir_tx) begin
      st_next.wid = 5'h00;
    end else if (st_reg.wid != 5'h1F) begin
      st_next.wid = st_reg.wid + 5'h01;
    end
    // Falling edge works for both pulse polarities: positive pulses decode late
    st_next.rx_prev = sir.rx_sync;
    if (st_reg.rx_prev && !sir.rx_sync) begin
      st_next.pend = 1'h1;
    end
    if (sir.tick) begin
      if (st_next.pend) begin
        st_next.int_rx = 1'h0;
        st_next.dec_cnt = 4'h0;
        st_next.pend = 1'h0;
      end else if (!st_reg.int_rx) begin
        if (st_reg.dec_cnt == rlm_pkg::DEC_LAST) begin
          st_next.int_rx = 1'h1;
        end else begin
          st_next.dec_cnt = st_reg.dec_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sir.ir_tx = st_reg.ir_tx;
  assign sir.int_rx = st_reg.int_rx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_enc_idle_low: assert property (sir.int_tx |=> !st_reg.ir_tx && st_reg.enc_cnt == 4'h0)
    else $error("encoder not idle while stream high");
  a_enc_rise_tick: assert property ($rose(st_reg.ir_tx) |-> st_reg.enc_cnt == rlm_pkg::ENC_RISE)
    else $error("infrared pulse rose at wrong tick");
  a_pulse_width_min: assert property ($fell(st_reg.ir_tx) && !$past(sir.int_tx)
      |-> $past(st_reg.wid) >= rlm_pkg::PULSE_MIN_CYC)
    else $error("infrared pulse too short");
  a_dec_edge_low: assert property (st_reg.pend && sir.tick |=> !st_reg.int_rx)
    else $error("decoder missed falling edge");
  a_dec_low_len: assert property ($rose(st_reg.int_rx) |-> $past(st_reg.dec_cnt) == 4'hF)
    else $error("decoded zero not sixteen ticks");

endmodule // rlm_sir_codec

// ==== core/rlm_sir_if.sv ====
// Carrier between the line-mode core and the infrared codec.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface rlm_sir_if;
  logic tick;
  logic int_tx;
  logic rx_sync;
  logic ir_tx;
  logic int_rx;
  modport core (output tick, output int_tx, output rx_sync, input ir_tx, input int_rx);
  modport codec (input tick, input int_tx, input rx_sync, output ir_tx, output int_rx);
endinterface // rlm_sir_if

// ==== tb/rlm_line_partner.sv ====
// Far-side model: RS-485 transceiver bus or infrared LED and photodiode pair.
// Assumes the bench clock; a pulse request is a one-cycle high on send.
`timescale 1ns/1ns
module rlm_line_partner #(
  parameter int PULSE_CLKS = 18
) (
  input wire logic clk,
  input wire logic ir_mode,
  input wire logic pos_pulse,
  input wire logic send,
  input wire logic tx_pin,
  input wire logic driver_enable_out,
  output logic rx_pin
);
  int left = 0;
  // Three coding ticks of six clocks, above the 1.6 us floor
  always @(posedge clk) begin
    if (send) begin
      left <= PULSE_CLKS;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  // A released bus sits high through the transceiver failsafe bias
  always_comb begin
    if (!ir_mode) begin
      rx_pin = driver_enable_out ? tx_pin : 1'b1;
    end else begin
      rx_pin = (left > 0) ^ !pos_pulse;
    end
  end
endmodule // rlm_line_partner

// ==== tb/tb.sv ====
// Self-checking bench for the line-mode block over Wishbone.
// Assumes a coding tick every six clocks, standing in for the UART core.
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic wb_ack_o, baud16_tick = 1'b0, int_tx = 1'b1, tsr_empty = 1'b1, thr_empty = 1'b1;
  logic thr_write = 1'b0, tx_stop_next = 1'b0, tx_int_raw = 1'b0, rx_pin, tx_pin;
  logic driver_enable_out, rx_line, rx_sample_strobe, rx_store_en, rx_int_en;
  logic rx_timeout_en, tx_int_req, ir_mode = 1'b0, pos_pulse = 1'b0, send = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  logic [7:0] gate_afc [6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
  logic listen, closed;
  int bad_count = 0, comparisons = 0, hi, rises;

  rlm_line_mode rlm_line_mode_inst (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .baud16_tick(baud16_tick), .int_tx(int_tx), .tsr_empty(tsr_empty),
    .thr_empty(thr_empty), .thr_write(thr_write), .tx_stop_next(tx_stop_next),
    .tx_int_raw(tx_int_raw), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .driver_enable_out(driver_enable_out), .rx_line(rx_line),
    .rx_sample_strobe(rx_sample_strobe), .rx_store_en(rx_store_en), .rx_int_en(rx_int_en),
    .rx_timeout_en(rx_timeout_en), .tx_int_req(tx_int_req));
  rlm_line_partner rlm_line_partner_inst (.clk(clk), .ir_mode(ir_mode),
    .pos_pulse(pos_pulse), .send(send), .tx_pin(tx_pin),
    .driver_enable_out(driver_enable_out), .rx_pin(rx_pin));

  always #50 clk = ~clk;
  // Coding tick at 1/6 of the clock keeps a 3-tick pulse at 1.8 us
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 3'h5) ? 3'h0 : tick_cnt + 3'h1;
    baud16_tick <= (tick_cnt == 3'h5);
  end

  task automatic results();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] din);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= din;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("BAD time=%0t bus timeout got=%h exp=%h", $time, n, 20);
      results();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb_cycle(1'b1, adr, d);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ticks(input int n);
    int i;
    int g;
    i = 0;
    g = 0;
    // Bounded: a stuck coding tick ends the run instead of hanging it
    while (i < n && g < 8 * n + 8) begin
      @(posedge clk);
      g++;
      if (baud16_tick === 1'b1) i++;
    end
    if (i < n) begin
      bad_count++;
      $display("BAD time=%0t tick timeout got=%h exp=%h", $time, i, n);
      results();
    end
  endtask

  // Counts high clocks and rising edges of one output over n clocks
  task automatic watch(input int sel, input int n);
    logic s, p;
    hi = 0;
    rises = 0;
    p = 1'b1;
    repeat (n) begin
      @(posedge clk);
      s = (sel == 0) ? tx_pin : (sel == 1) ? rx_line : rx_sample_strobe;
      if (s === 1'b1) hi++;
      if (s === 1'b1 && p !== 1'b1) rises++;
      p = s;
    end
  endtask

  task automatic pulse_in();
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
  endtask

  task automatic de_run(input logic [2:0] dly);
    wr(rlm_pkg::AFC_OFS, {24'h0, dly, 5'h04});
    tsr_empty <= 1'b0;
    thr_empty <= 1'b0;
    cyc(3);
    chk(driver_enable_out, 1'b0);
    tx_stop_next <= 1'b1;
    cyc(1);
    tx_stop_next <= 1'b0;
    cyc(3);
    chk(driver_enable_out, 1'b1);
    thr_empty <= 1'b1;
    ticks(20);
    chk(driver_enable_out, 1'b1);
    tsr_empty <= 1'b1;
    if (dly != 3'h0) begin
      ticks(16 * dly - 2);
      chk(driver_enable_out, 1'b1);
      ticks(4);
    end else begin
      cyc(3);
    end
    chk(driver_enable_out, 1'b0);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({tx_pin, driver_enable_out, rx_line, rx_sample_strobe, rx_store_en, rx_int_en,
      rx_timeout_en, tx_int_req}, 32'hAC);
    rd(rlm_pkg::AFC_OFS, 32'h0);
    rd(rlm_pkg::CTL_OFS, 32'h0);
    rd(rlm_pkg::STS_OFS, 32'hC);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'h0);
    wr(rlm_pkg::AFC_OFS, 32'hFF);
    rd(rlm_pkg::AFC_OFS, 32'hFF);
    wb_sel_i <= 4'hE;
    wr(rlm_pkg::AFC_OFS, 32'h00);
    wb_sel_i <= 4'hF;
    rd(rlm_pkg::AFC_OFS, 32'hFF);
    for (int e = 0; e < 2; e++) begin
      wr(rlm_pkg::CTL_OFS, 32'(e));
      for (int k = 0; k < 6; k++) begin
        wr(rlm_pkg::AFC_OFS, {24'h0, gate_afc[k]});
        cyc(2);
        listen = gate_afc[k][4];
        closed = (e == 0) && !listen && (gate_afc[k][2:1] != 2'b00);
        chk(rx_store_en, !closed);
        chk(rx_int_en, !closed);
        chk(rx_timeout_en, listen);
      end
    end
    // Echo: line stream loops inside, driver stays off
    wr(rlm_pkg::AFC_OFS, 32'h04);
    int_tx <= 1'b0;
    tx_stop_next <= 1'b1;
    cyc(1);
    tx_stop_next <= 1'b0;
    cyc(3);
    chk({rx_line, driver_enable_out, tx_pin}, 32'h1);
    int_tx <= 1'b1;
    cyc(3);
    chk(rx_line, 1'b1);
    wr(rlm_pkg::CTL_OFS, 32'h0);
    de_run(3'h0);
    de_run(3'h2);
    de_run(3'h7);
    // A write during the hold cancels it
    de_run(3'h1);
    tsr_empty <= 1'b0;
    tx_stop_next <= 1'b1;
    cyc(1);
    tx_stop_next <= 1'b0;
    tsr_empty <= 1'b1;
    ticks(4);
    rd(rlm_pkg::STS_OFS, 32'h7);
    thr_write <= 1'b1;
    thr_empty <= 1'b0;
    cyc(1);
    thr_write <= 1'b0;
    ticks(24);
    chk(driver_enable_out, 1'b1);
    thr_empty <= 1'b1;
    ticks(18);
    chk(driver_enable_out, 1'b0);
    wr(rlm_pkg::AFC_OFS, 32'h04);
    tx_int_raw <= 1'b1;
    tsr_empty <= 1'b0;
    cyc(3);
    chk(tx_int_req, 1'b0);
    tsr_empty <= 1'b1;
    cyc(3);
    chk(tx_int_req, 1'b1);
    wr(rlm_pkg::AFC_OFS, 32'h0C);
    tsr_empty <= 1'b0;
    cyc(3);
    chk(tx_int_req, 1'b1);
    tx_int_raw <= 1'b0;
    cyc(3);
    chk(tx_int_req, 1'b0);
    tsr_empty <= 1'b1;
    // Infrared encoder
    wr(rlm_pkg::AFC_OFS, 32'h02);
    watch(0, 120);
    chk(hi, 0);
    ticks(1);
    int_tx <= 1'b0;
    watch(0, 200);
    chk(hi, 36);
    chk(rises, 2);
    int_tx <= 1'b1;
    // Infrared decoder, negative then positive pulses
    ir_mode <= 1'b1;
    cyc(50);
    pulse_in();
    watch(2, 1300);
    chk(rises, 0);
    wr(rlm_pkg::AFC_OFS, 32'h12);
    cyc(10);
    pulse_in();
    watch(1, 300);
    chk(300 - hi, 96);
    cyc(1100);
    pulse_in();
    watch(2, 1300);
    chk(rises, 10);
    pos_pulse <= 1'b1;
    cyc(1500);
    pulse_in();
    watch(1, 18);
    chk(hi, 18);
    watch(1, 300);
    chk(300 - hi, 96);
    results();
  end
endmodule // tb
